// ### core/vliw_dispatch_regfile.sv
// fetch, execute packet dispatch, register access and data addressing
// assumes program memory answers a held fetch_req with a fetch_valid pulse
// Behaviour
// - fetch from program memory in whole 256-bit fetch packets
// - issue up to eight 32-bit instructions per clock, one per unit
// - chaining bit of each instruction decides packet membership
// - lsb one links next instruction, zero ends the packet
// - packets vary in length; units without an instruction stay idle
// - one packet per clock; refetch only after current packet drained
// - a packet may span two consecutive fetch packets, no padding
// - two sides, four units and a 32 x 32 file each
// - units read any own-side register, all in one cycle
// - each side has one cross bus from the opposite file
// - any unit on either side except the data unit may use the cross bus
// - cross reads pipelined so units share one cross register
// - one delay clock if cross-read register was written last clock
// - files hold packed, 32/40-bit and paired 64-bit values
// - computation on registers only; memory by loads and stores only
// - only data units reach memory; address and data side may differ
// - byte, half, word and doubleword transfers, one instruction each
// - non-aligned words and doublewords at any byte address
// - linear or circular addressing with 5- or 15-bit offsets
// - every instruction conditional on a register unless always true
`timescale 1ns/1ps
`default_nettype none
module vliw_dispatch_regfile #(
	parameter logic [31:0] RESET_PC  = 32'h0000_0000,
	parameter int          CIRC_LOG2 = 10
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	// program memory
	output logic                   fetch_req_r,
	output logic [31:0]            fetch_addr_r,
	input  wire logic              fetch_valid,
	input  wire logic [255:0]      fetch_data,
	// dispatch to units
	output logic [7:0]             unit_valid_r,
	output logic [7:0]             unit_cond_r,
	output logic [7:0][31:0]       unit_instr_r,
	output logic [7:0][31:0]       unit_opnd_a_r,
	output logic [7:0][31:0]       unit_opnd_b_r,
	// result and load write-back
	input  wire logic [7:0]        wb_en,
	input  wire logic [7:0]        wb_side,
	input  wire logic [7:0][4:0]   wb_addr,
	input  wire logic [7:0][31:0]  wb_data,
	// data memory
	output logic [1:0]             dmem_req_r,
	output logic [1:0]             dmem_we_r,
	output logic [1:0][1:0]        dmem_size_r,
	output logic [1:0][31:0]       dmem_addr_r,
	output logic [1:0][63:0]       dmem_wdata_r,
	output logic [1:0][5:0]        dmem_dst_r,
	// status
	output logic                   stall_r
);
	if (RESET_PC[4:0] != 5'h00 || CIRC_LOG2 < 1 || CIRC_LOG2 > 31)
	begin : g_chk
		$error("reset pc must be fetch aligned and circular size 1..31");
	end

	typedef logic [31:0] word_t;

	vliw_pkg::disp_state_e state_r, state_nxt;
	logic [255:0]   fp_r, fp_nxt;
	logic [2:0]     pos_r, pos_nxt;
	logic [7:0]     pend_valid_r, pend_valid_nxt;
	word_t          pend_instr_r [8];
	word_t          pend_instr_nxt [8];
	logic           stalled_r, stalled_nxt;
	logic [1:0][31:0] wr_prev_r, wr_prev_nxt;
	logic           fetch_req_nxt;
	logic [31:0]    fetch_addr_nxt;
	logic [7:0]     unit_valid_nxt, unit_cond_nxt;
	logic [7:0][31:0] unit_instr_nxt, unit_opnd_a_nxt, unit_opnd_b_nxt;
	logic [1:0]     dmem_req_nxt, dmem_we_nxt;
	logic [1:0][1:0]  dmem_size_nxt;
	logic [1:0][31:0] dmem_addr_nxt;
	logic [1:0][63:0] dmem_wdata_nxt;
	logic [1:0][5:0]  dmem_dst_nxt;
	logic           stall_nxt;

	// packet assembly
	logic [7:0]     pk_valid;
	word_t          pk_instr [8];
	logic           chain, done, hazard, issue;
	logic [2:0]     last;
	logic [2:0]     u_idx;
	word_t          slot;

	// register file ports
	logic [1:0][vliw_pkg::NRD-1:0][4:0]  rd_addr;
	logic [1:0][vliw_pkg::NRD-1:0][31:0] rd_data;
	logic [1:0][31:0] nz_mask, wr_mask;
	logic [1:0]       cross_set;

	// data address arithmetic
	logic           d_long, d_side, d_cond;
	logic [1:0]     d_size;
	logic [4:0]     d_reg;
	word_t          d_base, d_off, d_sum, d_addr, d_lo, d_hi;
	logic [5:0]     cmap;

	for (genvar s = 0; s < vliw_pkg::SIDES; s++)
	begin : g_side
		side_regfile #(
			.NRD  (vliw_pkg::NRD),
			.NWR  (vliw_pkg::UNITS),
			.SIDE (1'(s))
		) u_file (
			.ref_clk (ref_clk),
			.rst_b   (rst_b),
			.wr_en   (wb_en),
			.wr_side (wb_side),
			.wr_addr (wb_addr),
			.wr_data (wb_data),
			.rd_addr (rd_addr[s]),
			.rd_data (rd_data[s]),
			.nz_mask (nz_mask[s]),
			.wr_mask (wr_mask[s])
		);
	end

	// chain scan over the held fetch packet
	always_comb
	begin
		pk_valid = pend_valid_r;
		pk_instr = pend_instr_r;
		chain = 1'b1;
		last = pos_r;
		u_idx = 3'h0;
		slot = '0;
		for (int i = 0; i < vliw_pkg::SLOTS; i++)
			if (i >= int'(pos_r) && chain)
			begin
				slot = fp_r[i*vliw_pkg::INSTR_BITS +: vliw_pkg::INSTR_BITS];
				u_idx = slot[vliw_pkg::UNIT_LSB +: vliw_pkg::UNIT_W];
				pk_valid[u_idx] = 1'b1;
				pk_instr[u_idx] = slot;
				last = 3'(i);
				chain = slot[vliw_pkg::CHAIN_BIT];
			end
		done = !chain;
	end

	// operand addressing, cross buses and hazard check
	always_comb
	begin
		word_t w_instr;
		logic  w_side;
		w_instr = '0;
		w_side = 1'b0;
		rd_addr = '0;
		cross_set = '0;
		hazard = 1'b0;
		for (int u = 0; u < vliw_pkg::UNITS; u++)
		begin
			w_instr = pk_instr[u];
			w_side = u[2];
			// own-side reads, all units at once
			rd_addr[w_side][2*(u%4)] = w_instr[vliw_pkg::SRC1_LSB +: 5];
			rd_addr[w_side][2*(u%4)+1] = w_instr[vliw_pkg::SRC2_LSB +: 5];
			if (u % 4 == vliw_pkg::UNIT_DATA && w_instr[vliw_pkg::LONG_BIT])
				rd_addr[w_side][2*(u%4)+1] = vliw_pkg::LONG_BASE_REG;
			// data register pair on either file
			for (int f = 0; f < vliw_pkg::SIDES; f++)
				if (u % 4 == vliw_pkg::UNIT_DATA)
				begin
					rd_addr[f][vliw_pkg::RD_DATA+2*w_side] =
						w_instr[vliw_pkg::DST_LSB +: 5] & 5'h1e;
					rd_addr[f][vliw_pkg::RD_DATA+2*w_side+1] =
						w_instr[vliw_pkg::DST_LSB +: 5] | 5'h01;
				end
			// units share the first cross register
			if (pk_valid[u] && w_instr[vliw_pkg::X_BIT]
				&& u % 4 != vliw_pkg::UNIT_DATA)
			begin
				if (!cross_set[w_side])
					rd_addr[!w_side][vliw_pkg::RD_CROSS] =
						w_instr[vliw_pkg::SRC2_LSB +: 5];
				cross_set[w_side] = 1'b1;
				if (wr_prev_r[!w_side][w_instr[vliw_pkg::SRC2_LSB +: 5]])
					hazard = 1'b1;
			end
		end
		issue = done && (!hazard || stalled_r);
	end

	// next state of dispatch, fetch and issue registers
	always_comb
	begin
		word_t w_instr;
		w_instr = '0;
		state_nxt = state_r;
		fp_nxt = fp_r;
		pos_nxt = pos_r;
		pend_valid_nxt = pend_valid_r;
		pend_instr_nxt = pend_instr_r;
		stalled_nxt = 1'b0;
		stall_nxt = 1'b0;
		wr_prev_nxt = wr_mask;
		fetch_req_nxt = fetch_req_r;
		fetch_addr_nxt = fetch_addr_r;
		unit_valid_nxt = '0;
		unit_cond_nxt = '0;
		unit_instr_nxt = unit_instr_r;
		unit_opnd_a_nxt = unit_opnd_a_r;
		unit_opnd_b_nxt = unit_opnd_b_r;
		dmem_req_nxt = '0;
		dmem_we_nxt = '0;
		dmem_size_nxt = dmem_size_r;
		dmem_addr_nxt = dmem_addr_r;
		dmem_wdata_nxt = dmem_wdata_r;
		dmem_dst_nxt = dmem_dst_r;
		d_long = 1'b0;
		d_side = 1'b0;
		d_cond = 1'b0;
		d_size = vliw_pkg::SZ_BYTE;
		d_reg = 5'h00;
		d_base = '0;
		d_off = '0;
		d_sum = '0;
		d_addr = '0;
		d_lo = '0;
		d_hi = '0;
		cmap = '0;
		unique case (state_r)
			vliw_pkg::ST_FETCH:
			begin
				if (fetch_valid)
				begin
					fp_nxt = fetch_data;
					fetch_req_nxt = 1'b0;
					fetch_addr_nxt = fetch_addr_r + vliw_pkg::FP_BYTES;
					state_nxt = vliw_pkg::ST_ISSUE;
				end
			end
			vliw_pkg::ST_ISSUE:
			begin
				if (!done)
				begin
					// carry packet into next fetch packet
					pend_valid_nxt = pk_valid;
					pend_instr_nxt = pk_instr;
					pos_nxt = 3'h0;
					fetch_req_nxt = 1'b1;
					state_nxt = vliw_pkg::ST_FETCH;
				end
				else if (!issue)
				begin
					stall_nxt = 1'b1;
					stalled_nxt = 1'b1;
				end
				else
				begin
					pend_valid_nxt = '0;
					unit_valid_nxt = pk_valid;
					if (last == 3'h7)
					begin
						pos_nxt = 3'h0;
						fetch_req_nxt = 1'b1;
						state_nxt = vliw_pkg::ST_FETCH;
					end
					else
						pos_nxt = last + 3'h1;
					for (int u = 0; u < vliw_pkg::UNITS; u++)
					begin
						w_instr = pk_instr[u];
						unit_instr_nxt[u] = w_instr;
						unit_opnd_a_nxt[u] = rd_data[u/4][2*(u%4)];
						unit_opnd_b_nxt[u] = w_instr[vliw_pkg::X_BIT]
							? rd_data[1-u/4][vliw_pkg::RD_CROSS]
							: rd_data[u/4][2*(u%4)+1];
						cmap = vliw_pkg::COND_MAP[
							w_instr[vliw_pkg::CREG_LSB +: vliw_pkg::CREG_W]];
						unit_cond_nxt[u] = pk_valid[u] &&
							(w_instr[vliw_pkg::CREG_LSB +: vliw_pkg::CREG_W]
								== vliw_pkg::CREG_ALWAYS ||
							(nz_mask[cmap[5]][cmap[4:0]]
								^ w_instr[vliw_pkg::Z_BIT]));
					end
					for (int d = 0; d < vliw_pkg::SIDES; d++)
					begin
						w_instr = pk_instr[d*4+vliw_pkg::UNIT_DATA];
						d_cond = unit_cond_nxt[d*4+vliw_pkg::UNIT_DATA];
						d_long = w_instr[vliw_pkg::LONG_BIT];
						d_base = rd_data[d][2*vliw_pkg::UNIT_DATA+1];
						d_off = d_long
							? 32'(w_instr[vliw_pkg::OFFL_LSB +: vliw_pkg::OFFL_W])
							: 32'(w_instr[vliw_pkg::SRC1_LSB +: vliw_pkg::OFFS_W]);
						d_size = d_long ? vliw_pkg::SZ_WORD
							: w_instr[vliw_pkg::SIZE_LSB +: 2];
						d_sum = d_base + (d_off << d_size);
						d_addr = d_sum;
						if (w_instr[vliw_pkg::CIRC_BIT])
							d_addr = (d_base & ~((32'h0000_0001 << CIRC_LOG2)
								- 32'h0000_0001)) | (d_sum &
								((32'h0000_0001 << CIRC_LOG2) - 32'h0000_0001));
						if (!w_instr[vliw_pkg::NALIGN_BIT])
							d_addr = d_addr & ~((32'h0000_0001 << d_size)
								- 32'h0000_0001);
						// data side may differ from address side
						d_side = d_long ? 1'(d) : 1'(d) ^ w_instr[vliw_pkg::X_BIT];
						d_reg = w_instr[vliw_pkg::DST_LSB +: 5];
						d_lo = rd_data[d_side][vliw_pkg::RD_DATA+2*d];
						d_hi = rd_data[d_side][vliw_pkg::RD_DATA+2*d+1];
						if (d_size != vliw_pkg::SZ_DWORD)
						begin
							d_lo = rd_data[d_side][2*vliw_pkg::UNIT_DATA+1];
							d_lo = d_reg[0] ? d_hi : d_lo;
							if (d_reg[0] == 1'b0)
								d_lo = rd_data[d_side][vliw_pkg::RD_DATA+2*d];
							d_hi = 32'h0000_0000;
						end
						dmem_req_nxt[d] = d_cond;
						dmem_we_nxt[d] = d_cond && w_instr[vliw_pkg::ST_BIT];
						dmem_size_nxt[d] = d_size;
						dmem_addr_nxt[d] = d_addr;
						dmem_wdata_nxt[d] = {d_hi, d_lo};
						dmem_dst_nxt[d] = {d_side, d_reg};
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= vliw_pkg::ST_FETCH;
			fp_r <= '0;
			pos_r <= 3'h0;
			pend_valid_r <= '0;
			for (int u = 0; u < vliw_pkg::UNITS; u++)
				pend_instr_r[u] <= 32'h0000_0000;
			stalled_r <= 1'b0;
			wr_prev_r <= '0;
			fetch_req_r <= 1'b1;
			fetch_addr_r <= RESET_PC;
			unit_valid_r <= '0;
			unit_cond_r <= '0;
			unit_instr_r <= '0;
			unit_opnd_a_r <= '0;
			unit_opnd_b_r <= '0;
			dmem_req_r <= '0;
			dmem_we_r <= '0;
			dmem_size_r <= '0;
			dmem_addr_r <= '0;
			dmem_wdata_r <= '0;
			dmem_dst_r <= '0;
			stall_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			fp_r <= fp_nxt;
			pos_r <= pos_nxt;
			pend_valid_r <= pend_valid_nxt;
			pend_instr_r <= pend_instr_nxt;
			stalled_r <= stalled_nxt;
			wr_prev_r <= wr_prev_nxt;
			fetch_req_r <= fetch_req_nxt;
			fetch_addr_r <= fetch_addr_nxt;
			unit_valid_r <= unit_valid_nxt;
			unit_cond_r <= unit_cond_nxt;
			unit_instr_r <= unit_instr_nxt;
			unit_opnd_a_r <= unit_opnd_a_nxt;
			unit_opnd_b_r <= unit_opnd_b_nxt;
			dmem_req_r <= dmem_req_nxt;
			dmem_we_r <= dmem_we_nxt;
			dmem_size_r <= dmem_size_nxt;
			dmem_addr_r <= dmem_addr_nxt;
			dmem_wdata_r <= dmem_wdata_nxt;
			dmem_dst_r <= dmem_dst_nxt;
			stall_r <= stall_nxt;
		end
	end
endmodule
`default_nettype wire

// ### core/vliw_pkg.sv
// constants shared by the dispatch core and its register file sides
// assumes one core clock; instruction fields are this core's own encoding
package vliw_pkg;
	// fetch and execute packet geometry
	localparam int FP_BITS    = 256;
	localparam int INSTR_BITS = 32;
	localparam int SLOTS      = FP_BITS / INSTR_BITS;
	localparam int UNITS      = 8;
	localparam int SIDES      = 2;
	localparam int REGS       = 32;
	localparam int REG_AW     = 5;
	localparam logic [31:0] FP_BYTES = 32'h0000_0020;
	// instruction fields
	localparam int CHAIN_BIT  = 0;
	localparam int UNIT_LSB   = 1;
	localparam int UNIT_W     = 3;
	localparam int ST_BIT     = 4;
	localparam int LONG_BIT   = 5;
	localparam int CIRC_BIT   = 6;
	localparam int NALIGN_BIT = 7;
	localparam int SIZE_LSB   = 8;
	localparam int X_BIT      = 12;
	localparam int SRC1_LSB   = 13;
	localparam int SRC2_LSB   = 18;
	localparam int DST_LSB    = 23;
	localparam int Z_BIT      = 28;
	localparam int CREG_LSB   = 29;
	localparam int CREG_W     = 3;
	localparam int OFFL_LSB   = 8;
	localparam int OFFL_W     = 15;
	localparam int OFFS_W     = 5;
	// unit index within a side: logic, shift/branch, multiply, data address
	localparam int UNIT_DATA  = 3;
	localparam int UNITS_SIDE = 4;
	// transfer sizes
	localparam logic [1:0] SZ_BYTE  = 2'h0;
	localparam logic [1:0] SZ_HALF  = 2'h1;
	localparam logic [1:0] SZ_WORD  = 2'h2;
	localparam logic [1:0] SZ_DWORD = 2'h3;
	// base register of long-offset addressing
	localparam logic [4:0] LONG_BASE_REG = 5'h0f;
	// condition code to {side, register}; code 0 is always true
	localparam logic [CREG_W-1:0] CREG_ALWAYS = 3'h0;
	localparam logic [7:0][5:0] COND_MAP = {
		6'h23, 6'h00, 6'h02, 6'h01, 6'h22, 6'h21, 6'h20, 6'h00};
	// read port map of one side file
	localparam int RD_DATA  = 8;
	localparam int RD_CROSS = 12;
	localparam int NRD      = 13;
	// dispatcher states
	typedef enum logic [1:0] {
		ST_FETCH = 2'b01,
		ST_ISSUE = 2'b10
	} disp_state_e;
endpackage

// ### core/side_regfile.sv
// one side's 32 x 32 register file with many same-cycle read ports
// assumes write ports never target a register the same cycle twice
`timescale 1ns/1ps
`default_nettype none
module side_regfile #(
	parameter int         NRD  = 13,
	parameter int         NWR  = 8,
	parameter logic       SIDE = 1'b0
) (
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst_b,
	// write ports
	input  wire logic [NWR-1:0]             wr_en,
	input  wire logic [NWR-1:0]             wr_side,
	input  wire logic [NWR-1:0][4:0]        wr_addr,
	input  wire logic [NWR-1:0][31:0]       wr_data,
	// read ports
	input  wire logic [NRD-1:0][4:0]        rd_addr,
	output logic      [NRD-1:0][31:0]       rd_data,
	// register status
	output logic      [vliw_pkg::REGS-1:0]  nz_mask,
	output logic      [vliw_pkg::REGS-1:0]  wr_mask
);
	logic [31:0] mem_r   [vliw_pkg::REGS];
	logic [31:0] mem_nxt [vliw_pkg::REGS];

	if (NRD < 1 || NWR < 1)
	begin : g_chk
		$error("side_regfile needs at least one read and write port");
	end

	// all reads served in one cycle
	always_comb
	begin
		for (int p = 0; p < NRD; p++)
			rd_data[p] = mem_r[rd_addr[p]];
		for (int r = 0; r < vliw_pkg::REGS; r++)
			nz_mask[r] = |mem_r[r];
	end

	always_comb
	begin
		wr_mask = '0;
		for (int r = 0; r < vliw_pkg::REGS; r++)
			mem_nxt[r] = mem_r[r];
		for (int w = 0; w < NWR; w++)
			if (wr_en[w] && wr_side[w] == SIDE)
			begin
				mem_nxt[wr_addr[w]] = wr_data[w];
				wr_mask[wr_addr[w]] = 1'b1;
			end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			for (int r = 0; r < vliw_pkg::REGS; r++)
				mem_r[r] <= 32'h0000_0000;
		else
			mem_r <= mem_nxt;
	end
endmodule
`default_nettype wire

// ### tb/dispatch_monitor.sv
// checker for the fetch link, stall and issue ports of the dispatch core
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dispatch_monitor (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// fetch link
	input wire logic        fetch_req_r,
	input wire logic [31:0] fetch_addr_r,
	input wire logic        fetch_valid,
	// issue and status
	input wire logic [7:0]  unit_valid_r,
	input wire logic [7:0]  unit_cond_r,
	input wire logic [1:0]  dmem_req_r,
	input wire logic        stall_r
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	stall_idle_a: assert property (
		stall_r |-> unit_valid_r == 8'h00 && dmem_req_r == 2'h0)
		else $error("units issued in a delay clock");
	stall_once_a: assert property (
		stall_r |=> !stall_r)
		else $error("delay longer than one clock");
	stall_issue_a: assert property (
		stall_r |=> unit_valid_r != 8'h00)
		else $error("held packet not issued after delay");
	fetch_hold_a: assert property (
		fetch_req_r && !fetch_valid |=> fetch_req_r && $stable(fetch_addr_r))
		else $error("fetch request dropped or moved");
	fetch_step_a: assert property (
		fetch_req_r && fetch_valid |=>
		!fetch_req_r && fetch_addr_r == $past(fetch_addr_r) + 32'h0000_0020)
		else $error("fetch address not advanced by one packet");
	first_issue_a: assert property (
		fetch_req_r && fetch_valid |=> unit_valid_r == 8'h00)
		else $error("issue one cycle after fetch");
	fetch_quiet_a: assert property (
		$rose(fetch_req_r) |-> !stall_r)
		else $error("fetch started during a delay clock");
	cond_within_a: assert property (
		unit_cond_r != 8'h00 |-> (unit_cond_r & ~unit_valid_r) == 8'h00)
		else $error("condition without issue");
	dmem_unit_a: assert property (
		dmem_req_r != 2'h0 |-> (dmem_req_r & ~{unit_valid_r[7] & unit_cond_r[7],
		unit_valid_r[3] & unit_cond_r[3]}) == 2'h0)
		else $error("memory access without a passing data unit");
endmodule

bind vliw_dispatch_regfile dispatch_monitor u_dispatch_monitor (
	.ref_clk      (ref_clk),
	.rst_b        (rst_b),
	.fetch_req_r  (fetch_req_r),
	.fetch_addr_r (fetch_addr_r),
	.fetch_valid  (fetch_valid),
	.unit_valid_r (unit_valid_r),
	.unit_cond_r  (unit_cond_r),
	.dmem_req_r   (dmem_req_r),
	.stall_r      (stall_r)
);
`default_nettype wire

// ### tb/prog_mem_model.sv
// program memory answering fetch requests with whole fetch packets
// assumes the bench fills mem before releasing reset
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	// answer pace: 0 prompt, 1 three cycles later
	input  wire logic         slow,
	// fetch link
	input  wire logic         fetch_req_r,
	input  wire logic [31:0]  fetch_addr_r,
	output logic              fetch_valid,
	output logic [255:0]      fetch_data
);
	logic [255:0] mem [0:31];
	logic [1:0]   wait_r;

	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fetch_valid <= 1'b0;
			fetch_data  <= '0;
			wait_r      <= 2'h0;
		end
		else
		begin
			fetch_valid <= 1'b0;
			fetch_data  <= ~fetch_data;
			if (fetch_req_r && !fetch_valid)
			begin
				if (!slow || wait_r == 2'h3)
				begin
					fetch_valid <= 1'b1;
					fetch_data  <= mem[fetch_addr_r[9:5]];
					wait_r      <= 2'h0;
				end
				else
					wait_r <= wait_r + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/tb_vliw_dispatch_regfile.sv
// self-checking bench for packet dispatch, cross reads and data units
// assumes the program memory model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_vliw_dispatch_regfile;
	typedef struct packed {
		logic [7:0]       chain;
		logic [3:0]       count;
		logic [7:0][7:0]  masks;
	} row_s;
	typedef struct packed {
		logic [7:0]        mask;
		logic [7:0]        cond;
		logic [7:0][31:0]  opa;
		logic [7:0][31:0]  opb;
		logic [1:0]        dreq;
		logic [1:0]        dwe;
		logic [1:0][1:0]   dsize;
		logic [1:0][31:0]  daddr;
		logic [1:0][5:0]   ddst;
		logic [7:0]        stalls;
		logic [1:0][63:0]  dwd;
		logic [7:0][31:0]  ins;
	} issue_s;
	logic              ref_clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              slow = 1'b0;
	logic              fetch_req_r;
	logic [31:0]       fetch_addr_r;
	logic              fetch_valid;
	logic [255:0]      fetch_data;
	logic [7:0]        unit_valid_r;
	logic [7:0]        unit_cond_r;
	logic [7:0][31:0]  unit_opnd_a_r;
	logic [7:0][31:0]  unit_opnd_b_r;
	logic [7:0]        wb_en = 8'h00;
	logic [7:0]        wb_side = 8'h01;
	logic [7:0][4:0]   wb_addr = {30'h0, 5'h03, 5'h05};
	logic [7:0][31:0]  wb_data = {192'h0, 32'ha5a5_0003, 32'h1234_5678};
	logic [1:0]        dmem_req_r;
	logic [1:0]        dmem_we_r;
	logic [1:0][1:0]   dmem_size_r;
	logic [1:0][31:0]  dmem_addr_r;
	logic [1:0][5:0]   dmem_dst_r;
	logic [1:0][63:0]  dmem_wdata_r;
	logic [7:0][31:0]  unit_instr_r;
	logic              stall_r;
	logic [7:0]        stalls = 8'h00;
	issue_s            seen [$];
	logic [31:0]       takes [$];
	int                num_errors = 0;
	int                checks_done = 0;
	int                cycles = 0;
	row_s rows [0:5] = '{
		'{8'h00, 4'h8, 64'h8040_2010_0804_0201},
		'{8'h7f, 4'h1, 64'h0000_0000_0000_00ff},
		'{8'h55, 4'h4, 64'h0000_0000_c030_0c03},
		'{8'h80, 4'h7, 64'h0040_2010_0804_0201},
		'{8'h01, 4'h7, 64'h0080_4020_1008_0483},
		'{8'h0e, 4'h5, 64'h0000_0080_4020_1e01}};

	always #5 ref_clk = ~ref_clk;

	vliw_dispatch_regfile u_vliw_dispatch_regfile (
		.ref_clk (ref_clk), .rst_b (rst_b),
		.fetch_req_r (fetch_req_r), .fetch_addr_r (fetch_addr_r),
		.fetch_valid (fetch_valid), .fetch_data (fetch_data),
		.unit_valid_r (unit_valid_r), .unit_cond_r (unit_cond_r),
		.unit_instr_r (unit_instr_r), .unit_opnd_a_r (unit_opnd_a_r),
		.unit_opnd_b_r (unit_opnd_b_r), .wb_en (wb_en), .wb_side (wb_side),
		.wb_addr (wb_addr), .wb_data (wb_data), .dmem_req_r (dmem_req_r),
		.dmem_we_r (dmem_we_r), .dmem_size_r (dmem_size_r),
		.dmem_addr_r (dmem_addr_r), .dmem_wdata_r (dmem_wdata_r),
		.dmem_dst_r (dmem_dst_r), .stall_r (stall_r));

	prog_mem_model u_prog_mem_model (
		.ref_clk (ref_clk), .rst_b (rst_b), .slow (slow),
		.fetch_req_r (fetch_req_r), .fetch_addr_r (fetch_addr_r),
		.fetch_valid (fetch_valid), .fetch_data (fetch_data));

	// record every fetch take, delay clock and issued packet
	always @(posedge ref_clk)
	begin
		if (rst_b)
		begin
			if (stall_r)
				stalls = stalls + 8'h01;
			if (fetch_req_r && fetch_valid)
				takes.push_back(fetch_addr_r);
			if (unit_valid_r != 8'h00)
				seen.push_back('{unit_valid_r, unit_cond_r, unit_opnd_a_r,
					unit_opnd_b_r, dmem_req_r, dmem_we_r, dmem_size_r,
					dmem_addr_r, dmem_dst_r, stalls,
					dmem_wdata_r, unit_instr_r});
		end
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			close_out();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// slot i goes to unit i, chain bits from the given byte
	function automatic logic [255:0] fp_plain(input logic [7:0] chain);
		logic [255:0] p;
		for (int i = 0; i < 8; i++)
			p[32*i +: 32] = {28'h000_0000, 3'(i), chain[i]};
		return p;
	endfunction

	task automatic do_reset(input logic pace, input logic [7:0] wr);
		rst_b = 1'b0;
		slow = pace;
		wb_en = wr;
		stalls = 8'h00;
		seen.delete();
		takes.delete();
		repeat (3) @(posedge ref_clk);
		chk("reset fetch_req", 32'h0000_0001, 32'(fetch_req_r));
		chk("reset fetch_addr", 32'h0000_0000, fetch_addr_r);
		chk("reset units", 32'h0000_0000, 32'(unit_valid_r));
		chk("reset stall", 32'h0000_0000, 32'(stall_r));
		#1 rst_b = 1'b1;
	endtask

	task automatic wait_issues(input int n);
		int k;
		k = 0;
		while (seen.size() < n && k < 400)
		begin
			@(posedge ref_clk);
			#1 k++;
		end
		chk("issue count", 32'(n), 32'(seen.size()));
	endtask

	initial
	begin
		int k;
		logic [255:0] px;
		for (int pass = 0; pass < 2; pass++)
		begin
			for (int i = 0; i < 32; i++)
				u_prog_mem_model.mem[i] = fp_plain(i < 6 ? rows[i].chain : 8'h00);
			do_reset(pass[0], 8'h00);
			wait_issues(32);
			k = 0;
			for (int r = 0; r < 6; r++)
			begin
				chk("fetch addr", vliw_pkg::FP_BYTES * r, takes[r]);
				for (int j = 0; j < rows[r].count; j++)
				begin
					chk("mask", 32'(rows[r].masks[j]), 32'(seen[k].mask));
					chk("cond", 32'(rows[r].masks[j]), 32'(seen[k].cond));
					k++;
				end
			end
			chk("span instr", 32'h0000_000f, seen[20].ins[7]);
		end
		// cross reads of a register written every clock, and one written early
		px = fp_plain(8'h00);
		px[127:0] = {32'h0014_1001, 32'h0000_a00a, 32'h000c_1009, 32'h0014_1000};
		px[159:128] = 32'h0014_1004;
		for (int i = 0; i < 32; i++)
			u_prog_mem_model.mem[i] = (i == 0) ? px : fp_plain(8'h00);
		do_reset(1'b0, 8'h03);
		repeat (2) @(posedge ref_clk);
		#1 wb_en = 8'h01;
		wait_issues(3);
		chk("p1 mask", 32'h0000_0001, 32'(seen[0].mask));
		chk("p1 stalls", 32'h0000_0001, 32'(seen[0].stalls));
		chk("p1 cross", 32'h1234_5678, seen[0].opb[0]);
		chk("p2 mask", 32'h0000_0030, 32'(seen[1].mask));
		chk("p2 stalls", 32'h0000_0001, 32'(seen[1].stalls));
		chk("p2 cross b", 32'ha5a5_0003, seen[1].opb[4]);
		chk("p2 own", 32'h1234_5678, seen[1].opa[5]);
		chk("p2 instr", 32'h0000_a00a, seen[1].ins[5]);
		chk("p3 stalls", 32'h0000_0002, 32'(seen[2].stalls));
		chk("p3 cross u0", 32'h1234_5678, seen[2].opb[0]);
		chk("p3 cross u2", 32'h1234_5678, seen[2].opb[2]);
		// data units: sizes, store and load, failed condition
		px = fp_plain(8'h00);
		px[127:0] = {32'h0480_330e, 32'h0380_2206, 32'h2000_2116, 32'h3180_2016};
		for (int i = 0; i < 32; i++)
			u_prog_mem_model.mem[i] = (i == 0) ? px : fp_plain(8'h00);
		do_reset(1'b0, 8'h02);
		wait_issues(4);
		chk("st req", 32'h0000_0001, 32'(seen[0].dreq));
		chk("st we", 32'h0000_0001, 32'(seen[0].dwe[0]));
		chk("st addr", 32'h0000_0001, seen[0].daddr[0]);
		chk("st data lo", 32'ha5a5_0003, seen[0].dwd[0][31:0]);
		chk("st data hi", 32'h0000_0000, seen[0].dwd[0][63:32]);
		chk("nc req", 32'h0000_0000, 32'(seen[1].dreq));
		chk("nc cond", 32'h0000_0000, 32'(seen[1].cond));
		chk("ld we", 32'h0000_0000, 32'(seen[2].dwe[0]));
		chk("ld size", 32'h0000_0002, 32'(seen[2].dsize[0]));
		chk("ld addr", 32'h0000_0004, seen[2].daddr[0]);
		chk("ld dst", 32'h0000_0007, 32'(seen[2].ddst[0]));
		chk("dw req", 32'h0000_0002, 32'(seen[3].dreq));
		chk("dw size", 32'h0000_0003, 32'(seen[3].dsize[1]));
		chk("dw addr", 32'h0000_0008, seen[3].daddr[1]);
		chk("dw dst", 32'h0000_0009, 32'(seen[3].ddst[1]));
		close_out();
	end
endmodule
`default_nettype wire
